// ===== logic/sbat_top.v
// Serial bus arbiter bit timer with APB register access
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "sbat_defines.vh"

// What this block does
// - Low eight counter bits read as a read-only byte, zero after reset.
// - Any control register write clears the low eight counter bits.
// - Mode 00 holds the counter cleared and idle.
// - Clock select zero advances the counter at half the bus clock.
// - Clock select zero: falling receive edge starts, next falling edge stops.
// - Running flag shows counting; done flag sets when second fall stops it.
// - Clock select one advances at half the prescaled serial clock.
// - Clock select one starts on a low receive level, even at enable.
// - Clock select one stops at the next rising receive edge.
// - Mode 10 selects bus arbitration.
// - Arbitration restarts the counter on each rising transmit edge until arbitration is lost.
// - Receive is sampled at count 38h or 08h; low sets lost flag.
// - Lost flag forces the transmit pin high.
// - Transmit low before any receive low resets and waits for next rise.
// - Mode field: 00 idle, 01 measurement, 10 arbitration, 11 reserved.
// - Lost flag clears only by writing zero to the upper mode bit.
// - Counter overflow sets a flag cleared by any control write.
// - Counter top bit reads in control, cleared by any control write.
module sbat_top (
    // APB clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Serial side
    input wire rxd,
    input wire serial_tx_internal,
    input wire presc_tick,
    output wire txd_pin,
    // Interrupt
    output wire irq
);

// ----------------------------------------------------------------
// State codes
// ----------------------------------------------------------------
localparam ST_IDLE = 3'd0;
localparam ST_MWAIT = 3'd1;
localparam ST_MRUN = 3'd2;
localparam ST_MDONE = 3'd3;
localparam ST_AWAIT = 3'd4;
localparam ST_COUNT_RUNNING_FLAG = 3'd5;
localparam ST_AHOLD = 3'd6;

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
reg [2:0] st_q;
reg [2:0] st_d;
reg [1:0] arb_mode_field_q;
reg aclk_sel_q;
reg arb_lost_flag_q;
reg measure_done_flag_q;
reg count_overflow_flag_q;
reg phase_q;
reg smp_q;
reg smp_d;
reg [2:0] irq_stat_q;
reg [2:0] irq_mask_q;
reg [31:0] rdata_d;
reg cnt_clr;
reg count_running_flag;
reg done_set;
reg lost_set;
wire [8:0] cnt_q;
wire cnt_wrap;
wire cnt_inc;
wire src_tick;
wire rx_rise;
wire rx_fall;
wire tx_rise;
wire tx_fall;
wire setup;
wire access;
wire hit_count;
wire hit_ctrl;
wire hit_stat;
wire hit_mask;
wire hit;
wire wr_ctrl;
wire wr_mask;
wire rd_stat;
wire [1:0] wr_mode;
wire [8:0] arb_target;
wire [2:0] irq_ev;

// ----------------------------------------------------------------
// APB decode
// ----------------------------------------------------------------
assign setup = psel & ~penable;
assign access = psel & penable;
assign hit_count = (paddr == {2'b00, `SBAT_IDX_COUNT, 2'b00});
assign hit_ctrl = (paddr == {2'b00, `SBAT_IDX_CTRL, 2'b00});
assign hit_stat = (paddr == {2'b00, `SBAT_IDX_IRQ_STAT, 2'b00});
assign hit_mask = (paddr == {2'b00, `SBAT_IDX_IRQ_MASK, 2'b00});
assign hit = hit_count | hit_ctrl | hit_stat | hit_mask;

// Read data is captured in the setup cycle, so no wait state is needed
assign pready = access;
assign pslverr = access & ~hit;

// Count register takes no write and gives no error for one
assign wr_ctrl = access & pwrite & hit_ctrl;
assign wr_mask = access & pwrite & hit_mask;
assign rd_stat = access & ~pwrite & hit_stat;
assign wr_mode = {pwdata[`SBAT_CTL_MODE_HI], pwdata[`SBAT_CTL_MODE_LO]};

// ----------------------------------------------------------------
// Edge detectors
// ----------------------------------------------------------------
sbat_edge u_rx_edge (
    .pclk(pclk),
    .presetn(presetn),
    .din(rxd),
    .rise(rx_rise),
    .fall(rx_fall)
);

sbat_edge u_tx_edge (
    .pclk(pclk),
    .presetn(presetn),
    .din(serial_tx_internal),
    .rise(tx_rise),
    .fall(tx_fall)
);

// ----------------------------------------------------------------
// Counter clock
// ----------------------------------------------------------------
// Source is the bus clock or the prescaler tick
assign src_tick = aclk_sel_q ? presc_tick : 1'b1;

// Every second source tick advances the counter
assign cnt_inc = count_running_flag & src_tick & phase_q & ~cnt_clr;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        phase_q <= 1'b0;
    end else if (cnt_clr | ~count_running_flag) begin
        phase_q <= 1'b0;
    end else if (src_tick) begin
        phase_q <= ~phase_q;
    end
end

sbat_counter u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .clr(cnt_clr),
    .inc(cnt_inc),
    .cnt_q(cnt_q),
    .wrap(cnt_wrap)
);

assign arb_target = aclk_sel_q ? `SBAT_ARB_TGT_PRE : `SBAT_ARB_TGT_BUS;

// ----------------------------------------------------------------
// Mode sequencer
// ----------------------------------------------------------------
always @* begin
    st_d = st_q;
    smp_d = smp_q;
    cnt_clr = 1'b0;
    count_running_flag = 1'b0;
    done_set = 1'b0;
    lost_set = 1'b0;
    case (st_q)
        ST_IDLE: begin
            // Idle keeps the counter in reset
            cnt_clr = 1'b1;
            if (arb_mode_field_q == `SBAT_MODE_MEAS) begin
                st_d = ST_MWAIT;
            end else if (arb_mode_field_q == `SBAT_MODE_ARB) begin
                st_d = ST_AWAIT;
            end
        end
        ST_MWAIT: begin
            if (!aclk_sel_q && rx_fall) begin
                cnt_clr = 1'b1;
                st_d = ST_MRUN;
            end else if (aclk_sel_q && !rxd) begin
                // Level test also covers a line already low
                cnt_clr = 1'b1;
                st_d = ST_MRUN;
            end
        end
        ST_MRUN: begin
            count_running_flag = 1'b1;
            if ((!aclk_sel_q && rx_fall) || (aclk_sel_q && rx_rise)) begin
                done_set = 1'b1;
                st_d = ST_MDONE;
            end
        end
        ST_MDONE: begin
            // Captured length stays for software
            st_d = ST_MDONE;
        end
        ST_AWAIT: begin
            if (tx_rise) begin
                cnt_clr = 1'b1;
                smp_d = 1'b0;
                st_d = ST_COUNT_RUNNING_FLAG;
            end
        end
        ST_COUNT_RUNNING_FLAG: begin
            count_running_flag = 1'b1;
            if (tx_rise) begin
                cnt_clr = 1'b1;
                smp_d = 1'b0;
            end else if (cnt_q == arb_target && !smp_q) begin
                smp_d = 1'b1;
                if (!rxd) begin
                    lost_set = 1'b1;
                    st_d = ST_AHOLD;
                end
            end else if (tx_fall) begin
                // Own low bit went out unopposed
                cnt_clr = 1'b1;
                st_d = ST_AWAIT;
            end
        end
        ST_AHOLD: begin
            // Counter freezes until software re-arms
            st_d = ST_AHOLD;
        end
        default: begin
            st_d = ST_IDLE;
        end
    endcase
    // Reserved and idle settings fall back to reset
    if (arb_mode_field_q != `SBAT_MODE_MEAS &&
        arb_mode_field_q != `SBAT_MODE_ARB) begin
        st_d = ST_IDLE;
        cnt_clr = 1'b1;
        count_running_flag = 1'b0;
    end
    // A control write restarts whatever mode is written
    if (wr_ctrl) begin
        cnt_clr = 1'b1;
        smp_d = 1'b0;
        if (wr_mode == `SBAT_MODE_MEAS) begin
            st_d = ST_MWAIT;
        end else if (wr_mode == `SBAT_MODE_ARB) begin
            st_d = ST_AWAIT;
        end else begin
            st_d = ST_IDLE;
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        st_q <= ST_IDLE;
        smp_q <= 1'b0;
    end else begin
        st_q <= st_d;
        smp_q <= smp_d;
    end
end

// ----------------------------------------------------------------
// Control register
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        arb_mode_field_q <= `SBAT_RST_MODE;
        aclk_sel_q <= 1'b0;
    end else if (wr_ctrl) begin
        arb_mode_field_q <= wr_mode;
        aclk_sel_q <= pwdata[`SBAT_CTL_ACLK];
    end
end

// Hardware set wins over a same-cycle clear
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        arb_lost_flag_q <= 1'b0;
    end else if (lost_set) begin
        arb_lost_flag_q <= 1'b1;
    end else if (wr_ctrl && !pwdata[`SBAT_CTL_MODE_HI]) begin
        arb_lost_flag_q <= 1'b0;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        measure_done_flag_q <= 1'b0;
    end else if (done_set) begin
        measure_done_flag_q <= 1'b1;
    end else if (wr_ctrl) begin
        measure_done_flag_q <= 1'b0;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        count_overflow_flag_q <= 1'b0;
    end else if (cnt_wrap) begin
        count_overflow_flag_q <= 1'b1;
    end else if (wr_ctrl) begin
        count_overflow_flag_q <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Transmit override
// ----------------------------------------------------------------
// Recessive level keeps the loser off the shared wire
assign txd_pin = serial_tx_internal | arb_lost_flag_q;

// ----------------------------------------------------------------
// Interrupt status and mask
// ----------------------------------------------------------------
assign irq_ev[`SBAT_IRQ_DONE] = done_set;
assign irq_ev[`SBAT_IRQ_LOST] = lost_set;
assign irq_ev[`SBAT_IRQ_OVF] = cnt_wrap;

// Read clears the status; a fresh event in that cycle survives
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq_stat_q <= `SBAT_RST_IRQ;
    end else if (rd_stat) begin
        irq_stat_q <= irq_ev;
    end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq_mask_q <= `SBAT_RST_IRQ;
    end else if (wr_mask) begin
        irq_mask_q <= pwdata[2:0];
    end
end

assign irq = |(irq_stat_q & irq_mask_q);

// ----------------------------------------------------------------
// Read data
// ----------------------------------------------------------------
always @* begin
    rdata_d = 32'h0000_0000;
    if (hit_count) begin
        rdata_d[7:0] = cnt_q[7:0];
    end else if (hit_ctrl) begin
        rdata_d[`SBAT_CTL_MODE_HI] = arb_mode_field_q[1];
        rdata_d[`SBAT_CTL_MODE_LO] = arb_mode_field_q[0];
        rdata_d[`SBAT_CTL_LOST] = arb_lost_flag_q;
        rdata_d[`SBAT_CTL_ACLK] = aclk_sel_q;
        rdata_d[`SBAT_CTL_DONE] = measure_done_flag_q;
        rdata_d[`SBAT_CTL_RUN] = count_running_flag;
        rdata_d[`SBAT_CTL_OVF] = count_overflow_flag_q;
        rdata_d[`SBAT_CTL_TOP] = cnt_q[8];
    end else if (hit_stat) begin
        rdata_d[2:0] = irq_stat_q;
    end else if (hit_mask) begin
        rdata_d[2:0] = irq_mask_q;
    end
end

// Snapshot taken at setup; value is that of the setup cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
        prdata <= rdata_d;
    end
end

endmodule // sbat_top

// ===== logic/sbat_defines.vh
// Constants of the serial bus arbiter bit timer
`ifndef SBAT_DEFINES_VH
`define SBAT_DEFINES_VH

// Register indices, byte address is four times the index
`define SBAT_IDX_COUNT 4'hb
`define SBAT_IDX_CTRL 4'hc
`define SBAT_IDX_IRQ_STAT 4'hd
`define SBAT_IDX_IRQ_MASK 4'he

// Control register fields
`define SBAT_CTL_MODE_HI 7
`define SBAT_CTL_MODE_LO 6
`define SBAT_CTL_LOST 5
`define SBAT_CTL_ACLK 4
`define SBAT_CTL_DONE 3
`define SBAT_CTL_RUN 2
`define SBAT_CTL_OVF 1
`define SBAT_CTL_TOP 0

// Interrupt status and mask fields
`define SBAT_IRQ_DONE 0
`define SBAT_IRQ_LOST 1
`define SBAT_IRQ_OVF 2

// Mode field encodings
`define SBAT_MODE_IDLE 2'b00
`define SBAT_MODE_MEAS 2'b01
`define SBAT_MODE_ARB 2'b10

// Reset values
`define SBAT_RST_COUNT 9'h000
`define SBAT_RST_MODE 2'b00
`define SBAT_RST_IRQ 3'h0

// Arbitration sample points in counter ticks
`define SBAT_ARB_TGT_BUS 9'h038
`define SBAT_ARB_TGT_PRE 9'h008

`endif

// ===== logic/sbat_edge.v
// Edge detector for a synchronous level
`timescale 1ns/1ps

module sbat_edge (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Level in
    input wire din,
    // Edge pulses
    output wire rise,
    output wire fall
);

reg prev_q;

// Idle line is high, so the history starts high
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prev_q <= 1'b1;
    end else begin
        prev_q <= din;
    end
end

assign rise = din & ~prev_q;
assign fall = ~din & prev_q;

endmodule // sbat_edge

// ===== logic/sbat_counter.v
// Nine-bit counter with wrap pulse
`timescale 1ns/1ps
`include "sbat_defines.vh"

module sbat_counter (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Control
    input wire clr,
    input wire inc,
    // Status
    output reg [8:0] cnt_q,
    output wire wrap
);

assign wrap = inc & (&cnt_q);

// Clear takes priority over an advance in the same cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cnt_q <= `SBAT_RST_COUNT;
    end else if (clr) begin
        cnt_q <= `SBAT_RST_COUNT;
    end else if (inc) begin
        cnt_q <= cnt_q + 9'h001;
    end
end

endmodule // sbat_counter

// ===== dv/sbat_monitor.sv
// Port checker for the serial bus arbiter bit timer
`timescale 1ns/1ps
`include "sbat_defines.vh"

module sbat_monitor (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Serial side and interrupt
    input wire rxd,
    input wire serial_tx_internal,
    input wire presc_tick,
    input wire txd_pin,
    input wire irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // -------------------------------
    // Decode helpers
    // -------------------------------
    wire mapped = paddr[1:0] == 2'b00
        && paddr[7:2] >= {2'b00, `SBAT_IDX_COUNT}
        && paddr[7:2] <= {2'b00, `SBAT_IDX_IRQ_MASK};
    // Only a control write with the upper mode bit low may drop the lock
    wire clr_lost = psel && penable && pwrite && !pwdata[`SBAT_CTL_MODE_HI]
        && paddr[7:2] == {2'b00, `SBAT_IDX_CTRL};

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence

    // -------------------------------
    // Assertions
    // -------------------------------
    a_apb_zero_wait: assert property (s_setup ##1 s_access |-> pready)
        else $error("access phase without ready");
    a_err_unmapped: assert property (s_access and !mapped |-> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (s_access and mapped |-> !pslverr)
        else $error("mapped access refused");
    a_err_outside: assert property (!penable |-> !pslverr)
        else $error("error outside access phase");
    a_rdata_unmapped: assert property (
        s_access and (!mapped && !pwrite) |-> prdata == 32'h0)
        else $error("unmapped read returns data");
    a_rdata_hold: assert property (s_access |=> $stable(prdata))
        else $error("read data changed after access");
    a_txd_forced: assert property (serial_tx_internal |-> txd_pin)
        else $error("transmit pin low while sending high");
    a_lost_sticky: assert property (
        txd_pin && !serial_tx_internal && !clr_lost
        |=> txd_pin || serial_tx_internal)
        else $error("forced transmit level dropped without clear");
    a_irq_reset: assert property ($rose(presetn) |-> !irq)
        else $error("interrupt high after reset");
    // Reset must drop the transmit lock, so the pin follows the sender
    a_lock_reset: assert property (
        $rose(presetn) |-> txd_pin == serial_tx_internal)
        else $error("transmit lock survives reset");
endmodule // sbat_monitor

// ===== dv/sbat_bus_node.sv
// Model of the shared single-wire bus and another node on it
`timescale 1ns/1ps

module sbat_bus_node (
    // Line drivers
    input wire txd_pin,
    input wire other_low,
    // Line level
    output wire rxd
);
    // Open-drain line with pull-up: a dominant low from any node wins
    assign rxd = txd_pin & ~other_low;
endmodule // sbat_bus_node

// ===== dv/tb_top.sv
// Self-checking bench for the serial bus arbiter bit timer
`timescale 1ns/1ps
`include "sbat_defines.vh"

module tb_top;
    // -------------------------------
    // Signals
    // -------------------------------
    localparam logic [7:0] A_CNT = {2'b00, `SBAT_IDX_COUNT, 2'b00};
    localparam logic [7:0] A_CTL = {2'b00, `SBAT_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_ST = {2'b00, `SBAT_IDX_IRQ_STAT, 2'b00};
    localparam logic [7:0] A_MSK = {2'b00, `SBAT_IDX_IRQ_MASK, 2'b00};
    logic pclk, presetn, psel, penable, pwrite, tx, tick, dom, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd, v;
    wire [31:0] prdata;
    wire pready, pslverr, rxd, txd_pin, irq;
    int failures, tests_run, cyc, nt, c0, e;

    sbat_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
        .serial_tx_internal(tx), .presc_tick(tick), .txd_pin(txd_pin),
        .irq(irq));
    sbat_bus_node u_node (.txd_pin(txd_pin), .other_low(dom), .rxd(rxd));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Cut a hang short; the tests need about a sixth of this
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end

    // -------------------------------
    // Tasks
    // -------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Start and stop edges may land either side of a count step
    task automatic near(input logic [8:0] seen, input int exp);
        check(32'(seen + 1 >= exp && seen <= exp + 1), 32'h1);
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Falling-edge measurement over t cycles
    task automatic meas0(input int t, input logic [31:0] msk);
        apb(1'b1, A_MSK, msk);
        apb(1'b1, A_CTL, 32'h40);
        dom <= 1'b1;
        c0 = cyc;
        repeat (3) @(posedge pclk);
        dom <= 1'b0;
        apb(1'b0, A_CTL, 0);
        check(rd[`SBAT_CTL_RUN], 1);
        while (cyc != c0 + t) @(posedge pclk);
        dom <= 1'b1;
        @(posedge pclk);
        dom <= 1'b0;
        repeat (9) @(posedge pclk);
        e = t / 2;
        apb(1'b0, A_CNT, 0);
        v = rd;
        repeat (20) @(posedge pclk);
        apb(1'b0, A_CNT, 0);
        check(rd, v);
        apb(1'b0, A_CTL, 0);
        near({rd[`SBAT_CTL_TOP], v[7:0]}, e % 512);
        check(rd[3:1], {1'b1, 1'b0, e >= 512});
        check(irq, msk != 0);
        apb(1'b0, A_ST, 0);
        check(rd, {e >= 512, 2'b01});
        apb(1'b0, A_ST, 0);
        check(rd, 0);
        check(irq, 0);
        apb(1'b1, A_CTL, 32'h40);
        apb(1'b0, A_CNT, 0);
        check(rd, 0);
        apb(1'b0, A_CTL, 0);
        check(rd, 32'h40);
    endtask

    // -------------------------------
    // Main sequence
    // -------------------------------
    initial begin
        {psel, penable, pwrite, dom, tick, presetn} = 6'b0;
        tx = 1'b1;
        paddr = 8'h0;
        pwdata = 32'h0;
        v = $urandom(32'h23501360);
        fork
            forever begin
                @(posedge pclk);
                nt <= nt + tick;
                tick <= $urandom % 3 == 0;
            end
        join_none
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, A_CTL, 0);
        check(rd, 0);
        apb(1'b1, A_CNT, 32'hff);
        apb(1'b0, A_CNT, 0);
        check(rd, 0);
        apb(1'b0, 8'h3c, 0);
        check(err, 1);
        check(rd, 0);
        $display("register test done");
        // Idle and reserved modes keep the counter cleared
        for (e = 0; e < 2; e++) begin
            apb(1'b1, A_CTL, e * 32'hc0);
            repeat (3) begin
                dom <= 1'b1;
                repeat (6) @(posedge pclk);
                dom <= 1'b0;
                repeat (6) @(posedge pclk);
            end
            apb(1'b0, A_CNT, 0);
            check(rd, 0);
            apb(1'b0, A_CTL, 0);
            check(rd, e * 32'hc0);
        end
        $display("idle test done");
        meas0(60, 0);
        meas0(600, 7);
        meas0(1100, 7);
        $display("falling edge test done");
        // Break length on the prescaled clock, line already low at enable
        dom <= 1'b1;
        apb(1'b1, A_CTL, 32'h50);
        c0 = nt;
        repeat (100) @(posedge pclk);
        apb(1'b0, A_CTL, 0);
        check(rd[`SBAT_CTL_RUN], 1);
        repeat (100) @(posedge pclk);
        dom <= 1'b0;
        e = (nt - c0) / 2;
        repeat (10) @(posedge pclk);
        apb(1'b0, A_CNT, 0);
        near({1'b0, rd[7:0]}, e);
        apb(1'b0, A_CTL, 0);
        check(rd[`SBAT_CTL_RUN], 0);
        $display("break test done");
        // Another node holds the line dominant through the sample point
        for (e = 0; e < 2; e++) begin
            tx <= 1'b0;
            apb(1'b1, A_CTL, 32'h80 | (e << 4));
            apb(1'b0, A_ST, 0);
            tx <= 1'b1;
            dom <= 1'b1;
            repeat (200) @(posedge pclk);
            tx <= 1'b0;
            dom <= 1'b0;
            repeat (2) @(posedge pclk);
            check(txd_pin, 1);
            check(irq, 1);
            apb(1'b0, A_CTL, 0);
            check(rd[`SBAT_CTL_LOST], 1);
            apb(1'b0, A_ST, 0);
            check(rd, 32'h2);
            apb(1'b1, A_CTL, 32'h80);
            check(txd_pin, 1);
            apb(1'b1, A_CTL, 0);
            check(txd_pin, 0);
        end
        apb(1'b1, A_CTL, 32'h80);
        tx <= 1'b1;
        repeat (60) @(posedge pclk);
        tx <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, A_CNT, 0);
        check(rd, 0);
        tx <= 1'b1;
        repeat (20) @(posedge pclk);
        apb(1'b0, A_CNT, 0);
        near(rd[8:0], 10);
        repeat (200) @(posedge pclk);
        tx <= 1'b0;
        @(posedge pclk);
        check(txd_pin, 0);
        $display("arbitration test done");
        // Mid-run reset with the counter running in arbitration
        apb(1'b1, A_CTL, 32'h80);
        tx <= 1'b1;
        repeat (30) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, A_CNT, 0);
        check(rd, 0);
        apb(1'b0, A_CTL, 0);
        check(rd, 0);
        check(irq, 0);
        $display("reset test done");
        wrap_up();
    end
endmodule // tb_top

bind sbat_top sbat_monitor u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .serial_tx_internal(serial_tx_internal),
    .presc_tick(presc_tick), .txd_pin(txd_pin), .irq(irq));
